// >>> hw/pad_test_map.vh
// Purpose: Offsets, field positions, masks and reset values of the pad
//          drive and peripheral test mode register bank.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Definitions only.
`ifndef PAD_TEST_MAP_VH
`define PAD_TEST_MAP_VH

`define ADDR_W 8

// Byte offsets
`define OFS_PAD_DRIVE 8'h68
`define OFS_TEST_MODE 8'h80
`define OFS_CFG_UNLOCK 8'h90
`define OFS_LOCK_STATUS 8'h94

// Pad drive register fields
`define CLKWR_DRV_HI 31
`define CLKWR_DRV_LO 30
`define CLKWR_EDGE 28
`define IRQ_DRV_HI 27
`define IRQ_DRV_LO 26
`define IRQ_EDGE 24
`define SPK_DRV_HI 23
`define SPK_DRV_LO 22
`define SPK_EDGE 20
`define PAD_DRIVE_RST 32'h33333323
`define PAD_DRIVE_WMASK 32'hDDD00000

// Test mode register fields
`define SERIAL_TEST_BIT 2
`define DMA_TEST_BIT 1
`define TIMER_TEST_BIT 0
`define TEST_MODE_RST 8'h00
`define TEST_MODE_WMASK 8'h07

// Configuration unlock register
`define UNLOCK_BIT 0
`define CFG_UNLOCK_RST 8'h01
`define CFG_UNLOCK_WMASK 8'h01

// Lock status register
`define LOCKED_WR_BIT 0

`endif

// >>> hw/masked_reg_cell.v
// Purpose: Register whose writable bits are set by a mask; other bits
//          hold their reset value forever.
// Assumes: Caller supplies per-bit write enables already gated by lane.
// Notes:   Reset value and mask are parameters so reserved bits read as
//          constants, though store keeps a flip-flop for every bit.
`timescale 1ns/10ps
module masked_reg_cell #(
    parameter W = 32,
    parameter [W-1:0] RST = {W{1'b0}},
    parameter [W-1:0] WMASK = {W{1'b1}}
) (
    input wire pclk,
    input wire presetn,
    input wire [W-1:0] bit_we,
    input wire [W-1:0] wdata,
    output wire [W-1:0] q
);
    reg [W-1:0] store;
    wire [W-1:0] next_store;

    assign next_store = (store & ~bit_we) | (wdata & bit_we);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store <= RST;
        end else begin
            store <= next_store;
        end
    end

    // Reserved positions read their fixed value
    assign q = (store & WMASK) | (RST & ~WMASK);
endmodule // masked_reg_cell

// >>> hw/pad_drive_and_test_mode_regs.v
// Purpose: APB register bank for pad drive strength / edge rate of three
//          multiplexed pins and for peripheral test mode enables.
// Assumes: Single clock pclk at 50 MHz, presetn asynchronous active low.
// Notes:   Zero wait state; read data is captured in the setup cycle.
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`include "pad_test_map.vh"

// Contract
// - Bits 31-30 select clock-write pin drive
// - Bit 28 clock-write pin edge, 1 slow
// - Bits 27-26 irq pin drive 4/8/12/16 mA
// - Bit 24 irq pin edge, 1 slow
// - Bits 23-22 select speaker pin drive
// - Bit 20 speaker pin edge, 1 slow
// - Pad drive register resets to 33333323h
// - Test mode register at 80h resets 00h
// - Bit 2 enables serial port test mode
// - Bit 1 enables DMA controllers test mode
// - Bit 0 enables timer/counter test mode
// - Test bits writable only while unlocked
module pad_drive_and_test_mode_regs (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    output wire [1:0] clkwr_pin_drive_sel,
    output wire clkwr_pin_edge_sel,
    output wire [1:0] irq_pin_drive_sel,
    output wire irq_pin_edge_sel,
    output wire [1:0] speaker_pin_drive_sel,
    output wire speaker_pin_edge_sel,
    output reg [3:0] clkwr_mux_pin_ma,
    output reg [3:0] irq_mux_pin_ma,
    output reg [3:0] speaker_mux_pin_ma,
    output wire serial_port_test_en,
    output wire dma_test_en,
    output wire timer_test_en,
    output wire cfg_unlocked
);
    // Offsets held as sized constants so their word index can be sliced
    localparam [7:0] PAD_OFS = `OFS_PAD_DRIVE;
    localparam [7:0] TEST_OFS = `OFS_TEST_MODE;
    localparam [7:0] UNLOCK_OFS = `OFS_CFG_UNLOCK;
    localparam [7:0] STATUS_OFS = `OFS_LOCK_STATUS;

    // Bus phase decode
    wire setup_phase;
    wire access_phase;
    wire wr_access;
    reg hit;
    wire sel_pad;
    wire sel_test;
    wire sel_unlock;
    wire sel_status;
    wire addr_hit;

    // Register contents
    wire [31:0] pad_q;
    wire [7:0] test_q;
    wire [7:0] unlock_q;
    reg locked_wr_seen;
    reg next_locked_wr_seen;

    // Write enables
    wire [31:0] lane_mask;
    wire [31:0] pad_we;
    wire [7:0] test_we;
    wire [7:0] unlock_we;
    wire test_wr_try;
    wire test_wr_blocked;

    // Read path
    reg [31:0] next_prdata;

    // Current decode, one per pin
    wire [5:0] drive_codes;
    wire [11:0] ma_flat;

    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign wr_access = access_phase & pwrite & hit;

    assign sel_pad = (paddr[`ADDR_W-1:2] == PAD_OFS[`ADDR_W-1:2]);
    assign sel_test = (paddr[`ADDR_W-1:2] == TEST_OFS[`ADDR_W-1:2]);
    assign sel_unlock = (paddr[`ADDR_W-1:2] == UNLOCK_OFS[`ADDR_W-1:2]);
    assign sel_status = (paddr[`ADDR_W-1:2] == STATUS_OFS[`ADDR_W-1:2]);
    assign addr_hit = sel_pad | sel_test | sel_unlock | sel_status;

    // Hit is taken in setup so the access cycle sees a settled flag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit <= 1'b0;
        end else if (setup_phase) begin
            hit <= addr_hit;
        end
    end

    // Every transfer completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access_phase & ~hit;

    // Byte strobes widened to a bit mask
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
            assign lane_mask[lane*8 +: 8] = {8{pstrb[lane]}};
        end
    endgenerate

    // Only documented fields may be written
    assign pad_we = (wr_access & sel_pad) ?
        (lane_mask & `PAD_DRIVE_WMASK) : 32'h00000000;

    // Writes land only while the unlock bit is already set
    assign test_wr_try = wr_access & sel_test & pstrb[0];
    assign test_we = (test_wr_try & unlock_q[`UNLOCK_BIT]) ?
        `TEST_MODE_WMASK : 8'h00;
    assign test_wr_blocked = test_wr_try & ~unlock_q[`UNLOCK_BIT];

    assign unlock_we = (wr_access & sel_unlock & pstrb[0]) ?
        `CFG_UNLOCK_WMASK : 8'h00;

    masked_reg_cell #(
        .W(32),
        .RST(`PAD_DRIVE_RST),
        .WMASK(`PAD_DRIVE_WMASK)
    ) u_pad_drive (
        .pclk(pclk),
        .presetn(presetn),
        .bit_we(pad_we),
        .wdata(pwdata),
        .q(pad_q)
    );

    masked_reg_cell #(
        .W(8),
        .RST(`TEST_MODE_RST),
        .WMASK(`TEST_MODE_WMASK)
    ) u_test_mode (
        .pclk(pclk),
        .presetn(presetn),
        .bit_we(test_we),
        .wdata(pwdata[7:0]),
        .q(test_q)
    );

    masked_reg_cell #(
        .W(8),
        .RST(`CFG_UNLOCK_RST),
        .WMASK(`CFG_UNLOCK_WMASK)
    ) u_cfg_unlock (
        .pclk(pclk),
        .presetn(presetn),
        .bit_we(unlock_we),
        .wdata(pwdata[7:0]),
        .q(unlock_q)
    );

    // Sticky record of a refused test write; set wins over clear
    always @* begin
        next_locked_wr_seen = locked_wr_seen;
        if (wr_access & sel_status & pstrb[0] & pwdata[`LOCKED_WR_BIT]) begin
            next_locked_wr_seen = 1'b0;
        end
        if (test_wr_blocked) begin
            next_locked_wr_seen = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_wr_seen <= 1'b0;
        end else begin
            locked_wr_seen <= next_locked_wr_seen;
        end
    end

    // Field outputs straight from the register flops
    assign clkwr_pin_drive_sel = pad_q[`CLKWR_DRV_HI:`CLKWR_DRV_LO];
    assign clkwr_pin_edge_sel = pad_q[`CLKWR_EDGE];
    assign irq_pin_drive_sel = pad_q[`IRQ_DRV_HI:`IRQ_DRV_LO];
    assign irq_pin_edge_sel = pad_q[`IRQ_EDGE];
    assign speaker_pin_drive_sel = pad_q[`SPK_DRV_HI:`SPK_DRV_LO];
    assign speaker_pin_edge_sel = pad_q[`SPK_EDGE];

    assign serial_port_test_en = test_q[`SERIAL_TEST_BIT];
    assign dma_test_en = test_q[`DMA_TEST_BIT];
    assign timer_test_en = test_q[`TIMER_TEST_BIT];
    assign cfg_unlocked = unlock_q[`UNLOCK_BIT];

    // One-hot current strobe per pin: bit0 4 mA .. bit3 16 mA
    assign drive_codes = {speaker_pin_drive_sel, irq_pin_drive_sel,
        clkwr_pin_drive_sel};

    genvar pin;
    generate
        for (pin = 0; pin < 3; pin = pin + 1) begin : g_pin_ma
            reg [3:0] ma;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ma <= 4'h0;
                end else begin
                    case (drive_codes[pin*2 +: 2])
                        2'h0: ma <= 4'h1;
                        2'h1: ma <= 4'h2;
                        2'h2: ma <= 4'h4;
                        default: ma <= 4'h8;
                    endcase
                end
            end
            assign ma_flat[pin*4 +: 4] = ma;
        end
    endgenerate

    // Strobes lag the field by one clock; reset shows none selected
    always @* begin
        clkwr_mux_pin_ma = ma_flat[3:0];
        irq_mux_pin_ma = ma_flat[7:4];
        speaker_mux_pin_ma = ma_flat[11:8];
    end

    // Read mux; unmapped reads return zero
    always @* begin
        next_prdata = 32'h00000000;
        if (sel_pad) begin
            next_prdata = pad_q;
        end else if (sel_test) begin
            next_prdata = {24'h000000, test_q};
        end else if (sel_unlock) begin
            next_prdata = {24'h000000, unlock_q};
        end else if (sel_status) begin
            next_prdata = {31'h00000000, locked_wr_seen};
        end
    end

    // Captured in a read setup, held through access and until the next read setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_phase & ~pwrite) begin
            prdata <= next_prdata;
        end
    end
endmodule // pad_drive_and_test_mode_regs

// >>> tb/pad_bank_checker.sv
// Purpose: Concurrent checks on the pad drive / test mode register bank.
// Assumes: Single clock pclk, presetn asynchronous active low.
// Notes: Bound into the bank; watches only its ports.
`timescale 1ns/10ps
`include "pad_test_map.vh"
module pad_bank_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire pready,
    input wire pslverr,
    input wire [1:0] irq_pin_drive_sel,
    input wire clkwr_pin_edge_sel,
    input wire [3:0] irq_mux_pin_ma,
    input wire serial_port_test_en,
    input wire dma_test_en,
    input wire timer_test_en,
    input wire cfg_unlocked
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire [7:0] wa = {paddr[7:2], 2'b00};
    wire pad_wr = wr && wa == `OFS_PAD_DRIVE;
    wire tst_wr = wr && wa == `OFS_TEST_MODE;
    wire [2:0] tst = {serial_port_test_en, dma_test_en, timer_test_en};
    wire [2:0] tst_wd = pwdata[2:0];
    wire [1:0] irq_wd = pwdata[27:26];
    wire edge_wd = pwdata[28];
    wire mapped = wa == `OFS_PAD_DRIVE || wa == `OFS_TEST_MODE ||
        wa == `OFS_CFG_UNLOCK || wa == `OFS_LOCK_STATUS;
    AST_READY: assert property (acc |-> pready) else $error("pready low in access");
    AST_ERR: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
    AST_MA: assert property ($past(presetn) |-> irq_mux_pin_ma == (4'h1 << $past(irq_pin_drive_sel)))
        else $error("irq drive current not one-hot of select");
    AST_IRQ_WR: assert property (pad_wr && pstrb[3] |=> irq_pin_drive_sel == $past(irq_wd))
        else $error("irq drive select not written");
    AST_EDGE_WR: assert property (pad_wr && pstrb[3] |=> clkwr_pin_edge_sel == $past(edge_wd))
        else $error("clock-write edge not written");
    AST_HOLD: assert property (!pad_wr |=> $stable(irq_pin_drive_sel))
        else $error("irq drive select changed without write");
    AST_TEST_WR: assert property (tst_wr && pstrb[0] && cfg_unlocked |=> tst == $past(tst_wd))
        else $error("test bits not written while unlocked");
    AST_LOCKED: assert property (tst_wr && !cfg_unlocked |=> $stable(tst))
        else $error("test bits changed while locked");
    cover property (tst_wr && !cfg_unlocked);
    cover property (acc && pslverr);
    cover property (pad_wr && pstrb[3]);
endmodule // pad_bank_checker
bind pad_drive_and_test_mode_regs pad_bank_checker u_chk (.*);

// >>> tb/tb.sv
// Purpose: Self-checking bench for the pad drive / test mode register bank.
// Assumes: APB master with zero-wait slave; expectations from a bench model.
// Notes: Random data from a fixed seed, plus lock and unmapped corner cases.
`timescale 1ns/10ps
`include "pad_test_map.vh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ul, st;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, pad, r, q;
    logic [3:0] pstrb, clkwr_mux_pin_ma, irq_mux_pin_ma, speaker_mux_pin_ma;
    logic [1:0] clkwr_pin_drive_sel, irq_pin_drive_sel, speaker_pin_drive_sel;
    logic clkwr_pin_edge_sel, irq_pin_edge_sel, speaker_pin_edge_sel, cfg_unlocked;
    logic serial_port_test_en, dma_test_en, timer_test_en;
    logic [2:0] tm;
    integer n_mismatch, n_compared, seed, i;
    pad_drive_and_test_mode_regs DUT (.*);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    function [31:0] lanes(input [3:0] s);
        lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction
    task end_of_test;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared = n_compared + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    // Returns two edges after the access so the registered currents have landed
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        @(posedge pclk);
    endtask
    task ports;
        chk("clkwr drive", pad[31:30], clkwr_pin_drive_sel);
        chk("clkwr edge", pad[28], clkwr_pin_edge_sel);
        chk("irq drive", pad[27:26], irq_pin_drive_sel);
        chk("irq ma", 4'h1 << pad[27:26], irq_mux_pin_ma);
        chk("irq edge", pad[24], irq_pin_edge_sel);
        chk("spk drive", pad[23:22], speaker_pin_drive_sel);
        chk("spk edge", pad[20], speaker_pin_edge_sel);
        chk("clkwr ma", 4'h1 << pad[31:30], clkwr_mux_pin_ma);
        chk("spk ma", 4'h1 << pad[23:22], speaker_mux_pin_ma);
        chk("serial test", tm[2], serial_port_test_en);
        chk("dma test", tm[1], dma_test_en);
        chk("timer test", tm[0], timer_test_en);
        chk("unlocked", ul, cfg_unlocked);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s);
        q = `PAD_DRIVE_WMASK & lanes(s);
        if (a == `OFS_PAD_DRIVE) pad = (pad & ~q) | (d & q);
        if (a == `OFS_TEST_MODE && s[0] && !ul) st = 1'b1;
        if (a == `OFS_TEST_MODE && s[0] && ul) tm = d[2:0];
        if (a == `OFS_CFG_UNLOCK && s[0]) ul = d[0];
        if (a == `OFS_LOCK_STATUS && s[0] && d[0]) st = 1'b0;
        ports;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        chk("read data", e, rd);
        chk("read error", 1'b0, er);
    endtask
    task do_reset;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        pad = `PAD_DRIVE_RST;
        tm = 3'h0;
        ul = 1'b1;
        st = 1'b0;
        repeat (2) @(posedge pclk);
        ports;
        rdchk(`OFS_PAD_DRIVE, `PAD_DRIVE_RST);
        rdchk(`OFS_TEST_MODE, 32'h0);
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch = n_mismatch + 1;
        end_of_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        n_mismatch = 0;
        n_compared = 0;
        seed = 84105;
        @(posedge pclk);
        do_reset;
        for (i = 0; i < 4; i = i + 1) begin
            wr(`OFS_PAD_DRIVE, {16{i[1:0]}}, 4'hF);
            rdchk(`OFS_PAD_DRIVE, pad);
        end
        for (i = 0; i < 24; i = i + 1) begin
            r = $random(seed);
            q = $random(seed);
            wr(`OFS_PAD_DRIVE, r, q[3:0]);
            rdchk(`OFS_PAD_DRIVE, pad);
        end
        for (i = 0; i < 8; i = i + 1) begin
            r = $random(seed);
            wr(`OFS_TEST_MODE, {r[31:3], i[2:0]}, 4'hF);
            rdchk(`OFS_TEST_MODE, {29'h0, tm});
        end
        wr(`OFS_CFG_UNLOCK, 32'h0, 4'hF);
        wr(`OFS_TEST_MODE, {29'h0, ~tm}, 4'hF);
        rdchk(`OFS_TEST_MODE, {29'h0, tm});
        rdchk(`OFS_LOCK_STATUS, {31'h0, st});
        wr(`OFS_LOCK_STATUS, 32'h1, 4'hF);
        rdchk(`OFS_LOCK_STATUS, {31'h0, st});
        wr(`OFS_CFG_UNLOCK, 32'h1, 4'hF);
        apb(1'b1, 8'h44, $random(seed), 4'hF);
        chk("unmapped write error", 1'b1, er);
        apb(1'b0, 8'h44, 32'h0, 4'h0);
        chk("unmapped read error", 1'b1, er);
        chk("unmapped read data", 32'h0, rd);
        rdchk(`OFS_PAD_DRIVE, pad);
        do_reset;
        end_of_test;
    end
endmodule // tb
